// File: core/slh_pkg.sv
// Package for the stop exit and limp-home sequencer: constants, states and carriers.
package slh_pkg;
  localparam int SLH_CNT_W = 13;
  localparam logic [12:0] SLH_MID_COUNT = 13'h1000;
  localparam logic [12:0] SLH_SHORT_COUNT = 13'h0010;
  localparam logic [31:0] SLH_ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] SLH_ADDR_STAT = 32'h0000_0004;
  localparam logic [31:0] SLH_ADDR_CLKSEL = 32'h0000_0008;
  localparam int SLH_B_LHD = 0;
  localparam int SLH_B_CME = 1;
  localparam int SLH_B_FORCED_CLOCK_MONITOR_ENABLE = 2;
  localparam int SLH_B_DLY = 3;
  localparam int SLH_B_PSEUDO_STOP_ENABLE = 4;
  localparam int SLH_B_LIMP_HOME_IRQ_ENABLE = 5;
  localparam int SLH_B_AUTO = 6;
  localparam int SLH_B_LHS = 0;
  localparam int SLH_B_LIMP_HOME_CHANGE_FLAG = 1;
  localparam int SLH_B_STOPPED = 2;
  localparam int SLH_B_BUS_CLOCK_PLL_SELECT = 0;
  localparam int SLH_B_MCS = 1;
  localparam logic [6:0] SLH_CTRL_RST = 7'h41;
  localparam logic [1:0] SLH_CLKSEL_RST = 2'h0;

  typedef enum logic [2:0] {
    SLH_RUN = 3'b000,
    SLH_STOP = 3'b001,
    SLH_DELAY = 3'b010,
    SLH_LIMP = 3'b011,
    SLH_SHORT = 3'b100
  } slh_state_t;

  typedef struct packed {
    logic ext_reset;
    logic irq;
    logic xirq;
    logic kwu_j;
    logic kwu_h;
    logic can_wakeup;
  } slh_wake_t;

  typedef struct packed {
    logic limp_home_status;
    logic bus_clock_pll_select;
    logic module_clock_select;
    logic vco_run;
    logic osc_run;
    logic osc_low_amp;
    logic stop_active;
  } slh_clk_t;
endpackage

// File: core/slh_sequencer.sv
// Stop exit and limp-home sequencer with APB register access.
`timescale 1ns/10ps

// Functional notes
// - Limp-home allowed: STOP masks clock monitor so entry raises no failure.
// - Limp-home allowed: leaving STOP enters limp-home, monitor forced on.
// - With delay, count 4096 on VCO; good clock then resumes on oscillator.
// - No clock after 4096 delay: resume in limp-home, status and flag set.
// - In limp-home check monitor at mid-count, once every 8192 cycles.
// - Clock found: leave limp-home, clear status, set flag, irq if enabled.
// - No delay with crystal: release STOP at once, run in limp-home.
// - Leaving limp-home restores bus and module clock selects.
// - Auto bandwidth and PLL select set: relock PLL after limp-home.
// - Square wave source, no delay: status never set, STOP released at once.
// - Pseudo-stop enable makes STOP keep oscillator at reduced amplitude.
// - Wake on reset, IRQ, XIRQ, key wake-up J or H, CAN wake-up.
// - Pseudo-stop exit, limp allowed, delay: limp-home, PLL select high, module low.
// - After pseudo-stop delay resume on oscillator or limp-home with flags.
// - Pseudo-stop exit without delay restarts VCO for limp-home clock.
// - Limp-home disabled and monitor enabled: STOP gives clock monitor reset.
// - Limp disabled, monitor off, delay: oscillator start after 4096 cycles.
// - Limp disabled, monitor off, no delay: oscillator start after 16 cycles.
// - Delay enable gives 4096-count exit delay; clear gives none, or 16 counts with limp disabled.
// - Change flag clears on write of one; zero leaves it.
module slh_sequencer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stop_request,
  input wire slh_pkg::slh_wake_t wake,
  input wire logic counter_clock_en,
  input wire logic ext_clock_present,
  input wire logic pll_locked,
  output slh_pkg::slh_clk_t clk_ctl,
  output logic clock_monitor_active,
  output logic clock_monitor_reset,
  output logic pll_relock_request,
  output logic limp_home_change_flag,
  output logic limp_home_irq
);
  import slh_pkg::*;

  // RUN   : normal operation, a STOP request is accepted only here
  // STOP  : clocks halted; the oscillator runs on only in pseudo-stop
  // DELAY : exit delay on the counter, on the VCO when limp-home is allowed
  // LIMP  : software runs on the VCO; the monitor is polled at mid-count
  // SHORT : brief restart count when neither limp-home nor delay is used
  // Limitation: a held stop request with limp-home disabled and the monitor enabled keeps the reset high for as long as it is held

  slh_state_t state_q, state_d;
  logic [SLH_CNT_W-1:0] cnt_q;
  logic [6:0] ctrl_q;
  logic [1:0] clksel_q;
  logic [1:0] saved_sel_q;
  logic saved_auto_q;
  logic lhs_q;
  logic limp_home_change_flag_q;
  logic pseudo_q;
  logic [1:0] pres_sync_q;
  logic pres_s;
  slh_clk_t clk_q;
  logic cmr_q, relock_q, cma_q, irq_q;
  logic [31:0] rdata_q;

  assign pres_s = pres_sync_q[1];

  // APB decode; zero wait states
  wire apb_acc = psel & penable;
  wire apb_wr = apb_acc & pwrite;
  wire sel_ctrl = paddr == SLH_ADDR_CTRL;
  wire sel_stat = paddr == SLH_ADDR_STAT;
  wire sel_clks = paddr == SLH_ADDR_CLKSEL;
  wire unmapped = ~(sel_ctrl | sel_stat | sel_clks);
  wire wr_ctrl = apb_wr & sel_ctrl;
  wire wr_stat = apb_wr & sel_stat;
  wire wr_clks = apb_wr & sel_clks;

  wire lhd = ctrl_q[SLH_B_LHD];
  wire cme_any = ctrl_q[SLH_B_CME] | ctrl_q[SLH_B_FORCED_CLOCK_MONITOR_ENABLE];
  wire dly = ctrl_q[SLH_B_DLY];
  wire wake_any = |wake;
  wire in_limp = state_q == SLH_LIMP;
  wire stopping = state_q == SLH_RUN & stop_request;
  wire monitor_fail = stopping & lhd & cme_any;
  wire stop_enter = stopping & ~monitor_fail;
  wire wake_acc = state_q == SLH_STOP & wake_any;
  wire cnt_mid = counter_clock_en & cnt_q == SLH_MID_COUNT - 13'h0001;
  wire cnt_short = counter_clock_en & cnt_q == SLH_SHORT_COUNT - 13'h0001;
  // No-delay limp exit: a clean external source lets us skip limp-home entirely
  wire fast_clean = ~dly & pres_s & ~pseudo_q;
  wire delay_done = state_q == SLH_DELAY & cnt_mid;
  wire limp_check = in_limp & cnt_mid & pres_s;
  wire leave_limp = (delay_done & pres_s & ~lhd) | limp_check;
  wire enter_limp_flag = delay_done & ~pres_s & ~lhd;
  wire fast_limp = wake_acc & ~lhd & ~dly & ~fast_clean;
  wire lhs_set = enter_limp_flag | fast_limp;
  wire limp_home_change_flag_set = lhs_set | limp_check;
  wire limp_home_change_flag_clr = wr_stat & pwdata[SLH_B_LIMP_HOME_CHANGE_FLAG];

  // Next state; the exit path is chosen at the wake-up edge, and again at the end of the delay
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SLH_RUN: begin
        if (stop_enter) begin
          state_d = SLH_STOP;
        end
      end
      SLH_STOP: begin
        if (wake_acc) begin
          if (~lhd & dly) begin
            state_d = SLH_DELAY;
          end else if (~lhd & fast_clean) begin
            state_d = SLH_RUN;
          end else if (~lhd) begin
            state_d = SLH_LIMP;
          end else if (dly) begin
            state_d = SLH_DELAY;
          end else begin
            state_d = SLH_SHORT;
          end
        end
      end
      SLH_DELAY: begin
        // Without limp-home the oscillator is the only way out, so no check is made
        if (delay_done) begin
          state_d = (lhd | pres_s) ? SLH_RUN : SLH_LIMP;
        end
      end
      SLH_LIMP: begin
        if (limp_check) begin
          state_d = SLH_RUN;
        end
      end
      SLH_SHORT: begin
        if (cnt_short) begin
          state_d = SLH_RUN;
        end
      end
      default: begin
        state_d = SLH_RUN;
      end
    endcase
  end

  // Sequencing state, counter and the presence synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SLH_RUN;
      cnt_q <= '0;
      pres_sync_q <= 2'h0;
      pseudo_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pres_sync_q <= {pres_sync_q[0], ext_clock_present};
      if (stop_enter) begin
        pseudo_q <= ctrl_q[SLH_B_PSEUDO_STOP_ENABLE];
      end
      // Free-running count; its wrap gives the 8192-tick check period
      if (wake_acc) begin
        cnt_q <= '0;
      end else if (counter_clock_en) begin
        cnt_q <= cnt_q + 13'h0001;
      end
    end
  end

  // Registers; saved selects capture the values in force before limp-home
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= SLH_CTRL_RST;
      clksel_q <= SLH_CLKSEL_RST;
      saved_sel_q <= SLH_CLKSEL_RST;
      saved_auto_q <= 1'b0;
      lhs_q <= 1'b0;
      limp_home_change_flag_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= pwdata[6:0];
      end
      // Snapshot at wake-up; software may still edit the copy while limp-home runs
      if (wake_acc) begin
        saved_sel_q <= clksel_q;
        saved_auto_q <= ctrl_q[SLH_B_AUTO];
      end else if (wr_clks & (in_limp | state_q == SLH_DELAY)) begin
        saved_sel_q <= pwdata[1:0];
      end
      if (leave_limp) begin
        clksel_q <= saved_sel_q;
      end else if (wr_clks & state_q == SLH_RUN) begin
        clksel_q <= pwdata[1:0];
      end
      if (lhs_set) begin
        lhs_q <= 1'b1;
      end else if (leave_limp) begin
        lhs_q <= 1'b0;
      end
      // A change event in the cycle of a write of one keeps the flag set
      if (limp_home_change_flag_set) begin
        limp_home_change_flag_q <= 1'b1;
      end else if (limp_home_change_flag_clr) begin
        limp_home_change_flag_q <= 1'b0;
      end
    end
  end

  // Clock steering; outputs follow the next state so they move with the state register
  wire limp_clk = state_q == SLH_DELAY & ~lhd | in_limp;
  wire limp_next = state_d == SLH_DELAY & ~lhd | state_d == SLH_LIMP;
  wire stop_next = state_d == SLH_STOP;
  slh_clk_t clk_d;
  always_comb begin
    clk_d.limp_home_status = lhs_set | (lhs_q & ~leave_limp);
    clk_d.stop_active = stop_next | state_d == SLH_DELAY | state_d == SLH_SHORT;
    clk_d.bus_clock_pll_select = clksel_q[SLH_B_BUS_CLOCK_PLL_SELECT];
    clk_d.module_clock_select = clksel_q[SLH_B_MCS];
    if (limp_next) begin
      clk_d.bus_clock_pll_select = 1'b1;
      clk_d.module_clock_select = 1'b0;
    end
    clk_d.vco_run = ~stop_next;
    // Pseudo-stop keeps the oscillator alive so a delayed exit can resume on it
    clk_d.osc_run = ~stop_next | pseudo_q;
    clk_d.osc_low_amp = stop_next & pseudo_q;
  end

  // Relock only if auto is set and the saved bus select, as captured at wake-up or written since, picks the PLL
  wire relock_d = leave_limp & saved_auto_q & saved_sel_q[SLH_B_BUS_CLOCK_PLL_SELECT];
  wire relock_hold = relock_q & ~pll_locked;
  // Monitor masked in STOP, forced through a limp-allowed delay and limp-home, else as programmed
  wire cma_forced = limp_clk | state_d == SLH_LIMP;
  wire cma_d = stop_next ? 1'b0 : (cma_forced | cme_any);
  wire limp_home_change_flag_next = limp_home_change_flag_set | (limp_home_change_flag_q & ~limp_home_change_flag_clr);
  wire irq_d = limp_home_change_flag_next & ctrl_q[SLH_B_LIMP_HOME_IRQ_ENABLE];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_q <= '0;
      cmr_q <= 1'b0;
      relock_q <= 1'b0;
      cma_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      clk_q <= clk_d;
      cmr_q <= monitor_fail;
      relock_q <= relock_d | relock_hold;
      cma_q <= cma_d;
      irq_q <= irq_d;
    end
  end

  assign clk_ctl = clk_q;
  assign clock_monitor_reset = cmr_q;
  assign pll_relock_request = relock_q;
  assign clock_monitor_active = cma_q;
  assign limp_home_change_flag = limp_home_change_flag_q;
  assign limp_home_irq = irq_q;

  // Register read words
  wire [31:0] rd_ctrl = {25'h0, ctrl_q};
  wire [31:0] rd_stat = {29'h0, clk_q.stop_active, limp_home_change_flag_q, lhs_q};
  wire [31:0] rd_clks = {30'h0, clksel_q};
  wire [31:0] rd_mux = sel_ctrl ? rd_ctrl :
                       sel_stat ? rd_stat :
                       sel_clks ? rd_clks : 32'h0000_0000;

  // Ready and error are flops set by the setup phase, so they stand
  // for exactly the access cycle that follows; no wait states are added
  wire apb_setup = psel & ~penable;
  logic pready_q;
  logic slverr_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      slverr_q <= 1'b0;
    end else begin
      pready_q <= apb_setup;
      slverr_q <= apb_setup & unmapped;
      // Read data is captured in setup so it is steady through the access phase
      if (apb_setup & ~pwrite) begin
        rdata_q <= rd_mux;
      end
    end
  end
  assign prdata = rdata_q;
  assign pready = pready_q;
  assign pslverr = slverr_q;
endmodule

// File: testbench/slh_osc_model.sv
// External oscillator model feeding counter ticks and clock monitor status.
`timescale 1ns/10ps
module slh_osc_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic osc_on,
  output logic counter_clock_en,
  output logic ext_clock_present
);
  // Ticks every cycle so the long counts stay short in simulation
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_clock_en <= 1'b0;
      ext_clock_present <= 1'b0;
    end else begin
      counter_clock_en <= 1'b1;
      ext_clock_present <= osc_on;
    end
  end
endmodule

// File: testbench/slh_sequencer_props.sv
// Port checker for the stop exit and limp-home sequencer.
`timescale 1ns/10ps
module slh_sequencer_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pll_locked,
  input wire slh_pkg::slh_clk_t clk_ctl,
  input wire logic clock_monitor_active,
  input wire logic clock_monitor_reset,
  input wire logic pll_relock_request,
  input wire logic limp_home_change_flag,
  input wire logic limp_home_irq
);
  import slh_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  stop_mask_a: assert property (!clk_ctl.vco_run |-> !clock_monitor_active)
    else $error("monitor active in stop");
  limp_monitor_a: assert property (clk_ctl.limp_home_status |-> clock_monitor_active)
    else $error("monitor off in limp");
  limp_sel_a: assert property (clk_ctl.limp_home_status |-> clk_ctl.bus_clock_pll_select && !clk_ctl.module_clock_select)
    else $error("limp selects wrong");
  irq_gate_a: assert property (limp_home_irq |-> limp_home_change_flag)
    else $error("irq without flag");
  flag_set_a: assert property ($changed(clk_ctl.limp_home_status) |-> ##[0:1] limp_home_change_flag)
    else $error("flag not set");
  relock_hold_a: assert property (pll_relock_request && !pll_locked |=> pll_relock_request)
    else $error("relock dropped");
  relock_late_a: assert property ($rose(pll_relock_request) |-> !clk_ctl.limp_home_status)
    else $error("relock in limp");
  cmr_pulse_a: assert property (clock_monitor_reset |=> !clock_monitor_reset)
    else $error("reset pulse too long");
  cover property ($rose(clk_ctl.limp_home_status));
  cover property ($fell(clk_ctl.limp_home_status));
  cover property ($rose(clock_monitor_reset));
endmodule

// File: testbench/tb_top.sv
// Testbench for the stop exit and limp-home sequencer.
`timescale 1ns/10ps
module tb_top;
  import slh_pkg::*;
  logic clk, rst_n = 0, psel = 0, penable = 0, pwrite = 0, stop_request = 0, pll_locked = 0;
  logic osc_on = 1, pready, pslverr, last_err, cmr_seen = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata;
  slh_wake_t wake = '0;
  slh_clk_t clk_ctl;
  logic cce, ecp, cm_act, cm_rst, relock, flag, irq;
  int bad_count = 0, checked = 0, cycles = 0;
  slh_sequencer u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_request(stop_request), .wake(wake), .counter_clock_en(cce), .ext_clock_present(ecp),
    .pll_locked(pll_locked), .clk_ctl(clk_ctl), .clock_monitor_active(cm_act),
    .clock_monitor_reset(cm_rst), .pll_relock_request(relock), .limp_home_change_flag(flag),
    .limp_home_irq(irq));
  slh_osc_model u_osc (.clk(clk), .rst_n(rst_n), .osc_on(osc_on), .counter_clock_en(cce),
    .ext_clock_present(ecp));
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task automatic complete_run();
    if (bad_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(logic [31:0] g, logic [31:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask
  // One APB transfer; a read compares against e
  task automatic xf(logic w, logic [31:0] a, logic [31:0] d, logic [31:0] e);
    @(posedge clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    last_err = pslverr;
    if (!w) chk(prdata, e);
    psel <= 0; penable <= 0;
  endtask
  task automatic sleep(logic [5:0] w);
    @(posedge clk);
    stop_request <= 1;
    @(posedge clk);
    stop_request <= 0;
    cyc(2);
    wake <= slh_wake_t'(w);
    @(posedge clk);
    wake <= '0;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cm_rst === 1'b1) cmr_seen = 1;
    if (cycles == 40000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    cyc(5);
    rst_n <= 1;
    xf(0, SLH_ADDR_CTRL, 0, 32'h41);
    xf(0, 32'hC, 0, 0);
    chk(last_err, 1);
    xf(1, SLH_ADDR_CTRL, 32'h0, 0);
    for (int i = 0; i < 6; i++) begin
      sleep(6'h1 << i);
      cyc(3);
      chk(clk_ctl.stop_active, 0);
      chk(clk_ctl.limp_home_status, 0);
    end
    osc_on <= 0;
    cyc(4);
    sleep(6'h10);
    cyc(3);
    chk(clk_ctl.stop_active, 0);
    chk(clk_ctl.limp_home_status, 1);
    xf(1, SLH_ADDR_CLKSEL, 32'h2, 0);
    osc_on <= 1;
    cyc(4200);
    chk(clk_ctl.limp_home_status, 0);
    xf(0, SLH_ADDR_CLKSEL, 0, 32'h2);
    chk({clk_ctl.bus_clock_pll_select, clk_ctl.module_clock_select}, 2'b01);
    xf(1, SLH_ADDR_STAT, 32'h0, 0);
    xf(0, SLH_ADDR_STAT, 0, 32'h2);
    xf(1, SLH_ADDR_STAT, 32'h2, 0);
    xf(0, SLH_ADDR_STAT, 0, 32'h0);
    xf(1, SLH_ADDR_CTRL, 32'h08, 0);
    sleep(6'h04);
    cyc(4000);
    chk(clk_ctl.stop_active, 1);
    cyc(200);
    chk(clk_ctl.stop_active, 0);
    chk(clk_ctl.limp_home_status, 0);
    xf(1, SLH_ADDR_CLKSEL, 32'h3, 0);
    xf(1, SLH_ADDR_CTRL, 32'h68, 0);
    osc_on <= 0;
    sleep(6'h08);
    cyc(4200);
    chk({clk_ctl.limp_home_status, flag, irq}, 3'b111);
    chk({clk_ctl.bus_clock_pll_select, clk_ctl.module_clock_select}, 2'b10);
    xf(1, SLH_ADDR_STAT, 32'h2, 0);
    cyc(1);
    chk(irq, 0);
    osc_on <= 1;
    cyc(7800);
    chk(clk_ctl.limp_home_status, 1);
    cyc(400);
    chk({clk_ctl.limp_home_status, flag, irq}, 3'b011);
    chk({clk_ctl.bus_clock_pll_select, clk_ctl.module_clock_select}, 2'b11);
    chk(relock, 1);
    pll_locked <= 1;
    cyc(3);
    chk(relock, 0);
    xf(1, SLH_ADDR_CTRL, 32'h11, 0);
    sleep(6'h01);
    cyc(8);
    chk({clk_ctl.stop_active, clk_ctl.osc_run}, 2'b11);
    cyc(12);
    chk(clk_ctl.stop_active, 0);
    xf(1, SLH_ADDR_CTRL, 32'h03, 0);
    sleep(6'h00);
    chk(cmr_seen, 1);
    complete_run();
  end
endmodule
bind slh_sequencer slh_sequencer_props u_props (.clk(clk), .rst_n(rst_n), .pll_locked(pll_locked),
  .clk_ctl(clk_ctl), .clock_monitor_active(clock_monitor_active),
  .clock_monitor_reset(clock_monitor_reset), .pll_relock_request(pll_relock_request),
  .limp_home_change_flag(limp_home_change_flag), .limp_home_irq(limp_home_irq));
